/* hdl/ramp_zone_pkg.sv */
// package with register map, field layout, timing constants and carrier types
// Notes on behaviour
// [R01] the ramp register holds a three-bit rise step setting in bits 5..3 and a fall step setting in bits 2..0, bits 7..6 unused.
// [R02] step code 000 means 8 us per step, 001 means 1.024 ms, each higher code doubles, up to 32.768 ms at code 110.
// [R03] the zone register is read-only and is updated whenever the enabled light input reports entry into a different zone.
// [R04] each zone register update pulls the interrupt output low from its released state.
// [R05] a host read of the zone register releases the interrupt output, and the host must read it to clear an interrupt.
// [R06] bit 3 of the zone register is a change flag set on every zone change and cleared by a read of the register.
// [R07] bits 2..0 of the zone register hold the active zone 0 to 4 in binary, bits 7..4 read as zero.
// [R08] the ramped brightness is a seven-bit code, 0 meaning off and all ones meaning full scale.
// [R09] software must program the four zone limits in strictly increasing order for zone detection to work.
// [R10] while the applied brightness differs from its target it moves one code per step interval, using the rise time upward and fall time downward.
package ramp_zone_pkg;
   // register offsets
   localparam logic [7:0] RAMP_RATE_OFS   = 8'h30;
   localparam logic [7:0] ZONE_INFO_OFS   = 8'h40;
   // field positions
   localparam int         RISE_LSB        = 3;
   localparam int         FALL_LSB        = 0;
   localparam int         FLAG_BIT        = 3;
   // reset values and highest zone code
   localparam logic [5:0] RAMP_RESET      = 6'h00;
   localparam logic [2:0] ZONE_RESET      = 3'h0;
   localparam logic [6:0] BRIGHT_RESET    = 7'h00;
   localparam logic [2:0] ZONE_MAX        = 3'h4;
   // timing
   localparam int         CLK_HZ          = 10_000_000;
   localparam int         FAST_STEP_NS    = 8_000;
   localparam int         BASE_STEP_NS    = 1_024_000;
   localparam int         FAST_STEP_CYC   = (FAST_STEP_NS / 100 > 0) ? FAST_STEP_NS / 100 : 1;
   localparam int         BASE_STEP_CYC   = BASE_STEP_NS / (1_000_000_000 / CLK_HZ);
   localparam logic [2:0] STEP_CODE_MAX   = 3'h6;

   // register access from the serial bus front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // zone report from the sensor comparator
   typedef struct packed {
      logic       valid;
      logic [2:0] zone;
   } zone_evt_t;
endpackage

/* hdl/step_timer.sv */
// step interval timer: one-cycle tick each selected step time
`timescale 1ns/1ns
`default_nettype none
module step_timer
   import ramp_zone_pkg::*;
#(
   parameter int BASE_CYC = BASE_STEP_CYC,
   parameter int FAST_CYC = FAST_STEP_CYC
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // control
   input  wire logic       run_i,
   input  wire logic [2:0] code_i,
   // tick
   output logic            tick_o
);
   // refuse step counts that are empty or overflow the 24-bit counter at code 6
   if (BASE_CYC < 1 || FAST_CYC < 1 || FAST_CYC >= 2**24 || BASE_CYC >= 2**19) begin : g_bad_cyc
      $error("step counts out of range");
   end

   typedef struct packed {
      logic [23:0] cnt;
      logic        tick;
   } tmr_t;
   tmr_t r, nxt;
   logic [23:0] limit;

   // code 0 is the fast step, codes 1..6 double from the base step
   always_comb begin
      logic [2:0] c;
      c = (code_i > STEP_CODE_MAX) ? STEP_CODE_MAX : code_i;
      if (c == 3'h0) begin
         limit = 24'(FAST_CYC);                                  // [R02]
      end else begin
         limit = 24'(BASE_CYC) << (c - 3'h1);                    // [R02]
      end
   end

   // count cycles while ramping, tick on the last
   always_comb begin
      nxt = r;
      nxt.tick = 1'b0;
      if (!run_i) begin
         nxt.cnt = 24'h00_0000;
      end else if (r.cnt + 24'h00_0001 >= limit) begin
         nxt.cnt = 24'h00_0000;
         nxt.tick = 1'b1;
      end else begin
         nxt.cnt = r.cnt + 24'h00_0001;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign tick_o = r.tick;
endmodule
`default_nettype wire

/* hdl/ramp_zone.sv */
// brightness ramp rate control and ambient zone report with interrupt
`timescale 1ns/1ns
`default_nettype none
module ramp_zone
   import ramp_zone_pkg::*;
#(
   parameter int BASE_CYC = BASE_STEP_CYC
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // register access, same clock as the bus front end
   input  wire reg_req_t   req_i,
   output logic [7:0]      rdata_o,
   // brightness target and applied code
   input  wire logic [6:0] target_i,
   output logic [6:0]      brightness_code_o,
   // zone report from the ambient light input
   input  wire zone_evt_t  zone_i,
   // open-drain interrupt pin, low while enable is high
   output logic            int_o,
   output logic            int_oe_o
);
   typedef struct packed {
      logic [2:0] rise_sel;
      logic [2:0] fall_sel;
      logic [2:0] zone;
      logic       flag;
      logic       int_act;
      logic [6:0] bright;
      logic [7:0] rdata;
   } st_t;
   st_t r, nxt;

   logic       tick;
   logic       up;
   logic       moving;
   logic       zone_rd;
   logic       zone_upd;

   assign up       = target_i > r.bright;
   assign moving   = target_i != r.bright;
   assign zone_rd  = req_i.rd && req_i.addr == ZONE_INFO_OFS;
   // new zone seen only when it differs from the stored one
   assign zone_upd = zone_i.valid && zone_i.zone <= ZONE_MAX
                     && zone_i.zone != r.zone;                   // [R03] [R09]

   // step interval for the current direction
   step_timer #(
      .BASE_CYC (BASE_CYC),
      .FAST_CYC (FAST_STEP_CYC)
   ) u_timer (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .run_i    (moving),
      .code_i   (up ? r.rise_sel : r.fall_sel),                 // [R10]
      .tick_o   (tick)
   );

   // register file, ramp and zone state
   always_comb begin
      nxt = r;
      if (req_i.wr && req_i.addr == RAMP_RATE_OFS) begin
         nxt.rise_sel = req_i.wdata[RISE_LSB +: 3];             // [R01]
         nxt.fall_sel = req_i.wdata[FALL_LSB +: 3];             // [R01]
      end
      // read data, captured on the read strobe
      if (req_i.rd) begin
         unique case (req_i.addr)
            RAMP_RATE_OFS: nxt.rdata = {2'b00, r.rise_sel, r.fall_sel};
            ZONE_INFO_OFS: nxt.rdata = {4'h0, r.flag, r.zone};  // [R07] [R06]
            default:       nxt.rdata = 8'h00;
         endcase
      end
      // read releases the pin and clears the flag; a new change wins
      if (zone_rd) begin
         nxt.flag    = 1'b0;                                    // [R06]
         nxt.int_act = 1'b0;                                    // [R05]
      end
      if (zone_upd) begin
         nxt.zone    = zone_i.zone;                             // [R03] [R07]
         nxt.flag    = 1'b1;                                    // [R06]
         nxt.int_act = 1'b1;                                    // [R04]
      end
      // one code per step toward the target
      if (tick && moving) begin
         nxt.bright = up ? r.bright + 7'h01 : r.bright - 7'h01; // [R10] [R08]
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r          <= '0;
         r.rise_sel <= RAMP_RESET[5:3];
         r.fall_sel <= RAMP_RESET[2:0];
         r.zone     <= ZONE_RESET;
         r.bright   <= BRIGHT_RESET;
      end else begin
         r <= nxt;
      end
   end

   assign rdata_o           = r.rdata;
   assign brightness_code_o = r.bright;
   assign int_o             = 1'b0;      // constant low, pin driven only by enable
   assign int_oe_o          = r.int_act; // [R04] [R05]
endmodule
`default_nettype wire

/* tb/ramp_zone_chk.sv */
// assertion checker for the ramp and zone block
`timescale 1ns/1ns
`default_nettype none
module ramp_zone_chk import ramp_zone_pkg::*; (
   // watched ports
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire reg_req_t   req_i,
   input wire logic [7:0] rdata_o,
   input wire logic [6:0] target_i,
   input wire logic [6:0] brightness_code_o,
   input wire zone_evt_t  zone_i,
   input wire logic       int_o,
   input wire logic       int_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // host reads of the two registers
   sequence zrd; req_i.rd && req_i.addr == ZONE_INFO_OFS; endsequence
   sequence rrd; req_i.rd && req_i.addr == RAMP_RATE_OFS; endsequence
   ramp_rd_a: assert property (rrd |=> rdata_o[7:6] == 2'h0)
      else $error("ramp read top bits");
   int_pull_a: assert property ($rose(int_oe_o) |-> $past(zone_i.valid))
      else $error("interrupt without zone report");
   int_rel_a: assert property (zrd and !zone_i.valid |=> !int_oe_o)
      else $error("interrupt kept after read");
   flag_a: assert property (zrd |=> rdata_o[3] == $past(int_oe_o))
      else $error("change flag wrong");
   zone_fmt_a: assert property (zrd |=> rdata_o[7:4] == 4'h0 && rdata_o[2:0] <= ZONE_MAX)
      else $error("zone read format");
   zone_ro_a: assert property (
      req_i.wr && req_i.addr == ZONE_INFO_OFS && !zone_i.valid |=> $stable(int_oe_o))
      else $error("zone write had effect");
   pin_low_a: assert property (int_o == 1'b0) else $error("pin data not low");
   step_dir_a: assert property ($changed(brightness_code_o) |->
      (brightness_code_o == $past(brightness_code_o) + 7'h01
         && $past(target_i) > $past(brightness_code_o)) ||
      (brightness_code_o == $past(brightness_code_o) - 7'h01
         && $past(target_i) < $past(brightness_code_o)))
      else $error("bad brightness step");
   step_gap_a: assert property ($changed(brightness_code_o) |=> $stable(brightness_code_o)[*8])
      else $error("steps too close");
endmodule
bind ramp_zone ramp_zone_chk i_chk (.clk_i, .rst_i, .req_i, .rdata_o, .target_i,
   .brightness_code_o, .zone_i, .int_o, .int_oe_o);
`default_nettype wire

/* tb/host_model.sv */
// host processor model driving the register access port
`timescale 1ns/1ns
`default_nettype none
module host_model import ramp_zone_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output var reg_req_t    req_o
);
   initial req_o = '0;
   // one access held over its taking edge; reads of the zone register clear a pending interrupt
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge clk_i);
      req_o = '{w, !w, a, d};
      @(negedge clk_i);
      q = rdata_i;
      req_o = '{1'b0, 1'b0, ~a, ~d}; // released lines do not keep old values
   endtask
endmodule
`default_nettype wire

/* tb/ramp_zone_tb.sv */
// self-checking bench for the ramp and zone block
`timescale 1ns/1ns
`default_nettype none
module ramp_zone_tb import ramp_zone_pkg::*;;
   localparam int BC = 16;
   logic       clk_i = 0, rst_i = 1, int_o, int_oe_o;
   logic [7:0] rdata_o, q;
   logic [6:0] target_i = '0, bright;
   reg_req_t   req_i;
   zone_evt_t  zone_i = '0;
   int         miscompares = 0, n_tests = 0;
   initial forever #50 clk_i = ~clk_i;
   ramp_zone #(.BASE_CYC(BC)) i_dut (.clk_i, .rst_i, .req_i, .rdata_o, .target_i,
      .brightness_code_o(bright), .zone_i, .int_o, .int_oe_o);
   host_model i_host (.clk_i, .rdata_i(rdata_o), .req_o(req_i));
   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, e);
      i_host.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   // one-cycle zone report
   task automatic zev(input logic [2:0] z);
      @(negedge clk_i);
      zone_i = '{1'b1, z};
      @(negedge clk_i);
      zone_i = '{1'b0, ~z};
   endtask
   // new target, then cycles until reached must lie in lo..hi
   task automatic ramp(input logic [6:0] t, input int lo, hi);
      int n;
      n = 0;
      @(negedge clk_i);
      target_i = t;
      while (bright !== t && n < hi) begin
         @(negedge clk_i);
         n++;
      end
      n_tests++;
      if (n < lo || bright !== t) begin
         miscompares++;
         $display("[ERR] %0t ramp took %0d cycles", $time, n);
      end
   endtask
   task automatic report_and_stop;
      if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #(4000 * 100);
      miscompares++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(negedge clk_i);
      rst_i = 0;
      rd(RAMP_RATE_OFS, 8'h00);
      rd(ZONE_INFO_OFS, 8'h00);
      rd(8'h55, 8'h00);
      i_host.acc(1'b1, RAMP_RATE_OFS, 8'hFF, q);
      rd(RAMP_RATE_OFS, 8'h3F);
      zev(3'h2);
      chk({7'h0, int_oe_o}, 8'h01);
      chk({7'h0, int_o}, 8'h00);
      i_host.acc(1'b1, ZONE_INFO_OFS, 8'hFF, q);
      rd(ZONE_INFO_OFS, 8'h0A);
      chk({7'h0, int_oe_o}, 8'h00);
      zev(3'h2);
      zev(3'h5);
      rd(ZONE_INFO_OFS, 8'h02);
      for (int i = 0; i < 5; i++) begin
         zev(3'((i + 3) % 5));
         rd(ZONE_INFO_OFS, {5'h01, 3'((i + 3) % 5)});
      end
      // zone change in the same cycle as the clearing read: the change wins
      fork
         zev(3'h4);
         rd(ZONE_INFO_OFS, 8'h02);
      join
      chk({7'h0, int_oe_o}, 8'h01);
      rd(ZONE_INFO_OFS, 8'h0C);
      i_host.acc(1'b1, RAMP_RATE_OFS, 8'h08, q);
      ramp(7'h03, 3 * BC - 1, 3 * BC + 6);
      ramp(7'h00, 3 * 80 - 1, 3 * 80 + 6);
      i_host.acc(1'b1, RAMP_RATE_OFS, 8'h30, q);
      ramp(7'h01, 32 * BC - 1, 32 * BC + 6);
      report_and_stop;
   end
endmodule
`default_nettype wire
